/* rtl/member_constellation_monitor.sv */
// Contract
// - update order starts 30 s delay timer
// - active flag while timer runs; a setting change does not cancel a running order
// - notify all peers on accepted order
// - alarms of a layer suppressed during that layer's delay after its first cycle
// - snapshot live set shortly before expiry
// - afterwards compare live against stored set
// - stored member gone raises missing alarm
// - unknown member raises unexpected alarm
// - alarms also output as logic flags
// - id or upper setting change clears upper
// - lower setting change clears lower snapshot
// - lower snapshot holds group controllers, sync units
// - upper snapshot holds group units, sync units
// - redundant bus checked, redundancy loss alerted
// - order only on false-to-true trigger edge
`timescale 1ns/1ps
module member_constellation_monitor
    import member_monitor_pkg::*;
#(
    parameter longint unsigned DELAY_CYC = UPDATE_DELAY_CYC,
    parameter int unsigned     LEAD_CYC  = SNAP_LEAD_CYC
) (
    input  wire logic                            sys_clk,
    input  wire logic                            nrst,
    input  wire logic [LAYERS-1:0]               updateTrigger,
    input  wire member_monitor_pkg::layer_maps_t livePresence [LAYERS],
    input  wire logic [LAYERS-1:0]               redundantBus,
    input  wire logic [LAYERS-1:0]               peerUpdateActive,
    input  wire logic [LAYERS-1:0]               cfgChanged,
    output logic [LAYERS-1:0]                    updateActive,
    output logic [LAYERS-1:0]                    updateNotify,
    output member_monitor_pkg::layer_alarm_t     alarmFlags [LAYERS]
);
    import member_monitor_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers (trigger and peer flag come from outside)
    // ------------------------------------------------------------
    logic [LAYERS-1:0] trigMeta, trigSync, trigPrev;
    logic [LAYERS-1:0] peerMeta, peerSync;
    logic [LAYERS-1:0] next_trigMeta, next_trigSync, next_trigPrev;
    logic [LAYERS-1:0] next_peerMeta, next_peerSync;

    always_comb begin
        next_trigMeta = updateTrigger;
        next_trigSync = trigMeta;
        next_trigPrev = trigSync;
        next_peerMeta = peerUpdateActive;
        next_peerSync = peerMeta;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            trigMeta <= '0;
            trigSync <= '0;
            trigPrev <= '0;
            peerMeta <= '0;
            peerSync <= '0;
        end else begin
            trigMeta <= next_trigMeta;
            trigSync <= next_trigSync;
            trigPrev <= next_trigPrev;
            peerMeta <= next_peerMeta;
            peerSync <= next_peerSync;
        end
    end

    // ------------------------------------------------------------
    // per layer update sequencer and comparison
    // ------------------------------------------------------------
    localparam int unsigned CW = $clog2(DELAY_CYC + 1);

    for (genvar l = 0; l < LAYERS; l++) begin : g_layer
        upd_state_t  state, next_state;
        logic [CW-1:0] timer, next_timer;
        member_map_t  live [BUSES];
        member_map_t  stored [BUSES], next_stored [BUSES];
        logic         valid, next_valid;
        logic         notify, next_notify;
        logic         active, next_active;
        layer_alarm_t alarm, next_alarm;
        logic         orderEdge;
        logic         snapNow;

        // the live maps arrive from bus logic on this same clock
        assign live[0] = livePresence[l].busA;
        assign live[1] = livePresence[l].busB;
        // level held high blocks further orders until it drops
        assign orderEdge = trigSync[l] & ~trigPrev[l];
        assign snapNow   = (state == ST_DELAY) && (timer == CW'(LEAD_CYC));

        // ------------------------------------------------------------
        // per bus deviation against the stored reference
        // ------------------------------------------------------------
        // the redundant bus only counts when the layer is set up for it
        logic [BUSES-1:0] busUsed;
        logic [BUSES-1:0] busMissing;
        logic [BUSES-1:0] busExtra;

        for (genvar b = 0; b < BUSES; b++) begin : g_bus
            assign busUsed[b]    = (b == 0) || redundantBus[l];
            assign busMissing[b] = busUsed[b] && ((stored[b] & ~live[b]) != '0);
            assign busExtra[b]   = busUsed[b] && ((live[b] & ~stored[b]) != '0);
        end

        always_comb begin
            next_state  = state;
            next_timer  = timer;
            next_valid  = valid;
            next_notify = 1'b0;
            next_stored = stored;
            next_active = 1'b0;
            next_alarm  = '0;
            unique case (state)
                ST_IDLE, ST_MON: begin
                    if (orderEdge) begin
                        next_state  = ST_DELAY;
                        next_timer  = CW'(DELAY_CYC);
                        next_notify = 1'b1;
                    end
                end
                ST_DELAY: begin
                    // a retrigger during the delay is ignored; the running timer wins
                    next_timer = timer - CW'(1);
                    if (snapNow) begin
                        // lower layer: group controllers + sync units of the group,
                        // upper layer: group control units + upper sync units
                        for (int b = 0; b < BUSES; b++) begin
                            next_stored[b] = live[b];
                        end
                        next_valid = 1'b1;
                    end
                    if (timer == CW'(1)) begin
                        next_state = ST_MON;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
            next_active = (next_state == ST_DELAY);
            if (cfgChanged[l]) begin
                // id or interface change discards the snapshot
                next_valid = 1'b0;
                for (int b = 0; b < BUSES; b++) begin
                    next_stored[b] = '0;
                end
                if (state == ST_MON) begin
                    next_state = ST_IDLE;
                end
            end
            // no alarms while any member, this one included, is updating
            if (state == ST_MON && valid && !peerSync[l] && !cfgChanged[l]) begin
                next_alarm.missing    = |busMissing;
                next_alarm.unexpected = |busExtra;
                // member seen on one bus only: redundancy lost
                if (redundantBus[l] && live[0] != live[1]) begin
                    next_alarm.redundancyLost = 1'b1;
                end
            end
        end

        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                state  <= ST_IDLE;
                timer  <= '0;
                valid  <= 1'b0;
                notify <= 1'b0;
                active <= 1'b0;
                alarm  <= '0;
                for (int b = 0; b < BUSES; b++) begin
                    stored[b] <= '0;
                end
            end else begin
                state  <= next_state;
                timer  <= next_timer;
                valid  <= next_valid;
                notify <= next_notify;
                active <= next_active;
                alarm  <= next_alarm;
                for (int b = 0; b < BUSES; b++) begin
                    stored[b] <= next_stored[b];
                end
            end
        end

        assign updateActive[l] = active;
        assign updateNotify[l] = notify;
        assign alarmFlags[l]   = alarm;
    end

endmodule // member_constellation_monitor

/* shared/member_monitor_pkg.sv */
package member_monitor_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned UPDATE_DELAY_S   = 30;
    localparam longint unsigned UPDATE_DELAY_CYC = longint'(UPDATE_DELAY_S) * CLK_HZ;
    // snapshot is taken this many cycles before the delay ends
    localparam int unsigned SNAP_LEAD_CYC    = 16;

    // ------------------------------------------------------------
    // membership geometry
    // ------------------------------------------------------------
    localparam int unsigned MEMBERS  = 32;
    localparam int unsigned BUSES    = 2;
    localparam int unsigned LAYERS   = 2;
    localparam int unsigned LAYER_LO = 0;
    localparam int unsigned LAYER_HI = 1;

    typedef logic [MEMBERS-1:0] member_map_t;

    // live presence for one layer: primary and redundant bus
    typedef struct packed {
        member_map_t busB;
        member_map_t busA;
    } layer_maps_t;

    // alarm flags for one layer
    typedef struct packed {
        logic redundancyLost;
        logic unexpected;
        logic missing;
    } layer_alarm_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_MON   = 2'b10
    } upd_state_t;

endpackage

/* tb/member_monitor_chk.sv */
`timescale 1ns/1ps
module member_monitor_chk
    import member_monitor_pkg::*;
#(
    parameter longint unsigned DELAY_CYC = 100,
    parameter int unsigned     LEAD_CYC  = 4
) (
    input wire logic [1:0]   updateTrigger,
    input wire logic         sys_clk,
    input wire logic         nrst,
    input wire logic [1:0]   redundantBus,
    input wire logic [1:0]   cfgChanged,
    input wire logic [1:0]   updateActive,
    input wire logic [1:0]   updateNotify,
    input wire layer_maps_t  livePresence [LAYERS],
    input wire layer_alarm_t alarmFlags [LAYERS]
);
    // ----------------------------------------
    // active-cycle counters and layer 1 snapshot
    // ----------------------------------------
    logic [31:0] cnt [2];
    member_map_t snap;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= '{32'h0, 32'h0};
            snap <= '0;
        end else begin
            for (int i = 0; i < 2; i++) cnt[i] <= updateActive[i] ? cnt[i] + 32'h1 : 32'h0;
            if (updateActive[1] && cnt[1] == 32'(DELAY_CYC - LEAD_CYC)) snap <= livePresence[1].busA;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    notify_pulse_a: assert property (updateNotify[0] |=> !updateNotify[0])
        else $error("notify wider than one cycle");
    notify_start_a: assert property (updateNotify[1] |-> updateActive[1] && !$past(updateActive[1]))
        else $error("notify without a fresh delay");
    active_len_a: assert property ($fell(updateActive[0]) |-> cnt[0] == 32'(DELAY_CYC))
        else $error("delay length wrong");
    quiet_delay_a: assert property (updateActive[1] && $past(updateActive[1]) |-> alarmFlags[1] == '0)
        else $error("alarm during delay");
    cfg_clear_a: assert property (cfgChanged[0] |=> (alarmFlags[0] == '0)[*3])
        else $error("alarm after setting change");
    redund_loss_a: assert property (alarmFlags[0].redundancyLost |->
        $past(redundantBus[0] && livePresence[0].busA != livePresence[0].busB))
        else $error("redundancy alarm without cause");
    missing_cause_a: assert property (alarmFlags[1].missing |-> $past((snap & ~livePresence[1].busA) != '0))
        else $error("missing alarm without cause");
    extra_cause_a: assert property (alarmFlags[1].unexpected |-> $past((livePresence[1].busA & ~snap) != '0))
        else $error("unexpected alarm without cause");
endmodule // member_monitor_chk
bind member_constellation_monitor member_monitor_chk #(.DELAY_CYC(DELAY_CYC), .LEAD_CYC(LEAD_CYC)) chk (
    .updateTrigger(updateTrigger), .sys_clk(sys_clk), .nrst(nrst), .redundantBus(redundantBus),
    .cfgChanged(cfgChanged), .updateActive(updateActive), .updateNotify(updateNotify),
    .livePresence(livePresence), .alarmFlags(alarmFlags));

/* tb/peer_member_model.sv */
`timescale 1ns/1ps
module peer_member_model #(parameter int HOLD = 40) (
    input  wire logic [1:0] peerOrder,
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    output logic [1:0]      peerUpdateActive
);
    logic [1:0] prev;
    int         cnt [2];
    // a peer order counts on its rising edge only; the flag then stands for the peer delay
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev <= '0;
            cnt  <= '{0, 0};
        end else begin
            prev <= peerOrder;
            for (int i = 0; i < 2; i++) cnt[i] <= (peerOrder[i] && !prev[i]) ? HOLD : (cnt[i] > 0 ? cnt[i] - 1 : 0);
        end
    end
    always_comb for (int i = 0; i < 2; i++) peerUpdateActive[i] = cnt[i] > 0;
endmodule // peer_member_model

/* tb/member_constellation_monitor_test.sv */
`timescale 1ns/1ps
module member_constellation_monitor_test;
    import member_monitor_pkg::*;
    localparam longint unsigned DLY = 100;
    logic         sys_clk = 0, nrst = 0;
    logic [1:0]   updateTrigger = '0, redundantBus = '0, cfgChanged = '0, peerOrder = '0;
    logic [1:0]   peerUpdateActive, updateActive, updateNotify;
    layer_maps_t  livePresence [LAYERS] = '{default: '0};
    layer_alarm_t alarmFlags [LAYERS];
    int           errors = 0, cmp_count = 0;
    always #25 sys_clk = ~sys_clk;
    member_constellation_monitor #(.DELAY_CYC(DLY), .LEAD_CYC(4)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .updateTrigger(updateTrigger), .livePresence(livePresence), .redundantBus(redundantBus),
        .peerUpdateActive(peerUpdateActive), .cfgChanged(cfgChanged), .updateActive(updateActive),
        .updateNotify(updateNotify), .alarmFlags(alarmFlags));
    peer_member_model peers (.peerOrder(peerOrder), .sys_clk(sys_clk), .nrst(nrst),
        .peerUpdateActive(peerUpdateActive));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // trigger stays high on return; the live map turns to lateMap early in the delay
    task automatic order(int l, layer_maps_t lateMap, output int n);
        int w = 0;
        updateTrigger[l] = 1'b1;
        while (updateNotify[l] !== 1'b1 && w < 10) begin tick(); w++; end
        if (w == 10) begin errors++; tally_and_finish(); end
        check(updateActive[l], 1);
        tick();
        check(updateNotify[l], 0);
        n = 1;
        while (updateActive[l] === 1'b1 && n < 300) begin
            check(alarmFlags[l], 0);
            if (n == 10) livePresence[l] = lateMap;
            n++;
            tick();
        end
    endtask
    task automatic t_update;
        int n;
        livePresence[1].busA = 32'h0000_0003;
        order(1, {32'h0, 32'h0000_000f}, n);
        check(n, 32'(DLY));
        tick(2);
        check(alarmFlags[1], 0);
        tick(10);
        check(updateNotify[1] | updateActive[1], 0);
        updateTrigger[1] = 1'b0;
        $display("test update done");
    endtask
    task automatic t_alarms;
        livePresence[1].busA = 32'h0000_0007;
        tick(2);
        check(alarmFlags[1], 3'b001);
        livePresence[1].busA = 32'h0000_001f;
        tick(2);
        check(alarmFlags[1], 3'b010);
        livePresence[1].busA = 32'h0000_0017;
        tick(2);
        check(alarmFlags[1], 3'b011);
        peerOrder[1] = 1'b1;
        tick(5);
        check(alarmFlags[1], 0);
        peerOrder[1] = 1'b0;
        tick(45);
        check(alarmFlags[1], 3'b011);
        cfgChanged[1] = 1'b1;
        tick();
        cfgChanged[1] = 1'b0;
        tick(3);
        check(alarmFlags[1], 0);
        $display("test alarms done");
    endtask
    task automatic t_redund;
        int n;
        redundantBus[0] = 1'b1;
        livePresence[0] = {32'h0000_0003, 32'h0000_0003};
        order(0, {32'h0000_0003, 32'h0000_0003}, n);
        updateTrigger[0] = 1'b0;
        check(n, 32'(DLY));
        livePresence[0].busB = 32'h0000_0001;
        tick(2);
        check(alarmFlags[0], 3'b101);
        cfgChanged[0] = 1'b1;
        tick();
        cfgChanged[0] = 1'b0;
        tick(2);
        check(alarmFlags[0], 0);
        $display("test redundancy done");
    endtask
    // reset early in the delay: everything drops, trigger released before reset ends
    task automatic t_reset;
        int n;
        updateTrigger[1] = 1'b1;
        tick(6);
        check(updateActive[1], 1);
        nrst = 1'b0;
        tick();
        check({updateActive, updateNotify}, 0);
        check(alarmFlags[1], 0);
        updateTrigger[1] = 1'b0;
        nrst = 1'b1;
        tick(2);
        check(updateActive[1], 0);
        order(1, livePresence[1], n);
        updateTrigger[1] = 1'b0;
        check(n, 32'(DLY));
        tick(2);
        check(alarmFlags[1], 0);
        $display("test reset done");
    endtask
    initial begin
        tick(4);
        nrst = 1'b1;
        tick(2);
        t_update();
        t_alarms();
        t_redund();
        t_reset();
        tally_and_finish();
    end
endmodule // member_constellation_monitor_test
